// [src/iar_cfg.svh]
// Opcodes, time-state counts and reset values of the immediate ALU and rotate datapath.
`ifndef IAR_CFG_SVH
`define IAR_CFG_SVH

// ==========================================================
// Opcodes
`define IAR_OP_SUB_IMM_PLAIN 8'h14
`define IAR_OP_SUB_IMM_BORROW 8'h1C
`define IAR_OP_AND_IMM 8'h24
`define IAR_OP_XOR_IMM 8'h2C
`define IAR_OP_OR_IMM 8'h34
`define IAR_OP_COMPARE_IMM 8'h3C
`define IAR_OP_ROTATE_LEFT_CIRCULAR 8'h02
`define IAR_OP_ROTATE_RIGHT_CIRCULAR 8'h0A
`define IAR_OP_ROTATE_LEFT_VIA_CARRY 8'h12
`define IAR_OP_ROTATE_RIGHT_VIA_CARRY 8'h1A

// ==========================================================
// Immediate group pattern: bits 7:6 and 2:0 of the opcode.
`define IAR_IMM_HI 2'h0
`define IAR_IMM_LO 3'h4

// ==========================================================
// Time states, one clock each.
`define IAR_T_FETCH 3'h5
`define IAR_T_READ 3'h3
`define IAR_T_FIRST 3'h1

// ==========================================================
// Reset values.
`define IAR_ACC_RST 8'h00
`define IAR_FLAG_RST 1'h0

`endif

// [src/iar_pkg.sv]
// Types shared by the immediate ALU and rotate datapath.
package iar_pkg;
  // ==========================================================
  // Machine cycle sequencer states, Gray coded along idle, fetch, read.
  typedef enum logic [1:0] {
    IAR_IDLE = 2'h0,
    IAR_FETCH = 2'h1,
    IAR_READ = 2'h3
  } iar_state_t;
endpackage

// [src/iar_flag_eval.sv]
// Zero, sign and parity evaluation of one result byte.
`timescale 1ns/100ps
module iar_flag_eval (
  input wire logic [7:0] value,
  output logic zero,
  output logic sign,
  output logic parity
);
  // ==========================================================
  // Flag terms
  // Parity reads one for an even number of ones in the byte.
  assign zero = (value == 8'h00);
  assign sign = value[7];
  assign parity = ~(^value);
endmodule

// [src/iar_alu.sv]
// Accumulator datapath for immediate arithmetic, logic and rotate operations.
// Operation
// - Borrow subtract: accumulator minus byte two minus carry, stored back.
// - Borrow subtract uses carry left by a preceding plain immediate subtract.
// - AND immediate stores accumulator AND byte two.
// - XOR immediate stores accumulator XOR byte two.
// - OR immediate stores accumulator OR byte two.
// - Compare keeps accumulator; carry when byte two larger; zero when equal.
// - Compare sets sign and parity as the subtraction would.
// - Immediate operations take eight time states: fetch then read cycle.
// - Rotates change only carry and move the accumulator one bit.
// - Rotates are one byte and take five time states, fetch only.
// - Rotate left circular: bit 7 into bit 0 and carry.
// - Rotate right circular: bit 0 into bit 7 and carry.
// - Rotate left via carry: old carry into bit 0, bit 7 into carry.
// - Rotate right via carry: old carry into bit 7, bit 0 into carry.
// - Immediate operations are two bytes; operand byte follows the opcode, never altered.
`timescale 1ns/100ps
`include "iar_cfg.svh"
module iar_alu (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [7:0] DATA_IN,
  input wire logic LOAD,
  input wire logic [7:0] LOAD_ACC,
  input wire logic LOAD_CARRY,
  output logic [7:0] ACC,
  output logic CARRY,
  output logic ZERO,
  output logic SIGN,
  output logic PARITY,
  output logic BUSY,
  output logic DONE,
  output logic MEM_READ,
  output logic [2:0] TSTATE
);
  // ==========================================================
  // State
  iar_pkg::iar_state_t state_reg, state_next;
  logic [2:0] t_reg, t_next;
  logic [7:0] op_reg;
  logic [7:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic zero_reg, zero_next;
  logic sign_reg, sign_next;
  logic parity_reg, parity_next;
  logic busy_reg, done_reg, mem_read_reg;

  // ==========================================================
  // Decode
  // Any opcode of the immediate pattern fetches a second byte, even ones this block ignores.
  wire take = START & ~busy_reg;
  wire is_imm = (op_reg[7:6] == `IAR_IMM_HI) && (op_reg[2:0] == `IAR_IMM_LO);
  wire fetch_end = (state_reg == iar_pkg::IAR_FETCH) && (t_reg == `IAR_T_FETCH);
  wire read_end = (state_reg == iar_pkg::IAR_READ) && (t_reg == `IAR_T_READ);
  wire exec_rot = fetch_end & ~is_imm;
  wire exec_imm = read_end;
  wire op_sui = (op_reg == `IAR_OP_SUB_IMM_PLAIN);
  wire op_sbb = (op_reg == `IAR_OP_SUB_IMM_BORROW);
  wire op_and = (op_reg == `IAR_OP_AND_IMM);
  wire op_xor = (op_reg == `IAR_OP_XOR_IMM);
  wire op_or = (op_reg == `IAR_OP_OR_IMM);
  wire op_cmp = (op_reg == `IAR_OP_COMPARE_IMM);
  wire op_rlc = (op_reg == `IAR_OP_ROTATE_LEFT_CIRCULAR);
  wire op_rrc = (op_reg == `IAR_OP_ROTATE_RIGHT_CIRCULAR);
  wire op_ral = (op_reg == `IAR_OP_ROTATE_LEFT_VIA_CARRY);
  wire op_rar = (op_reg == `IAR_OP_ROTATE_RIGHT_VIA_CARRY);

  // ==========================================================
  // Arithmetic and logic results
  // A nine-bit difference keeps the borrow in its top bit, so carry means borrow.
  wire borrow_in = op_sbb & carry_reg;
  wire [8:0] diff = {1'b0, acc_reg} - {1'b0, DATA_IN} - {8'h00, borrow_in};
  wire [7:0] and_res = acc_reg & DATA_IN;
  wire [7:0] xor_res = acc_reg ^ DATA_IN;
  wire [7:0] or_res = acc_reg | DATA_IN;
  wire [7:0] rlc_res = {acc_reg[6:0], acc_reg[7]};
  wire [7:0] rrc_res = {acc_reg[0], acc_reg[7:1]};
  wire [7:0] ral_res = {acc_reg[6:0], carry_reg};
  wire [7:0] rar_res = {carry_reg, acc_reg[7:1]};
  wire is_sub = op_sui | op_sbb | op_cmp;
  wire is_logic = op_and | op_xor | op_or;
  wire [7:0] logic_res = op_and ? and_res : (op_xor ? xor_res : or_res);
  // Compare evaluates flags on the difference it throws away.
  wire [7:0] flag_src = is_sub ? diff[7:0] : logic_res;
  wire f_zero, f_sign, f_parity;

  iar_flag_eval u_flags (
    .value(flag_src),
    .zero(f_zero),
    .sign(f_sign),
    .parity(f_parity)
  );

  // ==========================================================
  // Next accumulator and flags
  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    sign_next = sign_reg;
    parity_next = parity_reg;
    if (LOAD && !busy_reg) begin
      acc_next = LOAD_ACC;
      carry_next = LOAD_CARRY;
    end else if (exec_imm && (is_sub || is_logic)) begin
      // Logic operations clear carry, since no borrow can arise.
      acc_next = op_cmp ? acc_reg : (is_sub ? diff[7:0] : logic_res);
      carry_next = is_sub ? diff[8] : 1'b0;
      zero_next = f_zero;
      sign_next = f_sign;
      parity_next = f_parity;
    end else if (exec_rot) begin
      // Zero, sign and parity keep their values here.
      unique case (1'b1)
        op_rlc: begin
          acc_next = rlc_res;
          carry_next = acc_reg[7];
        end
        op_rrc: begin
          acc_next = rrc_res;
          carry_next = acc_reg[0];
        end
        op_ral: begin
          acc_next = ral_res;
          carry_next = acc_reg[7];
        end
        op_rar: begin
          acc_next = rar_res;
          carry_next = acc_reg[0];
        end
        default: acc_next = acc_reg;
      endcase
    end
  end

  // ==========================================================
  // Sequencer next state
  // A one-byte opcode ends after the fetch; an immediate one reads its operand byte.
  always_comb begin
    state_next = state_reg;
    t_next = t_reg + 3'h1;
    unique case (state_reg)
      iar_pkg::IAR_IDLE: begin
        t_next = 3'h0;
        if (take) begin
          state_next = iar_pkg::IAR_FETCH;
          t_next = `IAR_T_FIRST;
        end
      end
      iar_pkg::IAR_FETCH: begin
        if (fetch_end) begin
          state_next = is_imm ? iar_pkg::IAR_READ : iar_pkg::IAR_IDLE;
          t_next = is_imm ? `IAR_T_FIRST : 3'h0;
        end
      end
      iar_pkg::IAR_READ: begin
        if (read_end) begin
          state_next = iar_pkg::IAR_IDLE;
          t_next = 3'h0;
        end
      end
      default: begin
        state_next = iar_pkg::IAR_IDLE;
        t_next = 3'h0;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= iar_pkg::IAR_IDLE;
      t_reg <= 3'h0;
      op_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      mem_read_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      t_reg <= t_next;
      if (take) op_reg <= OPCODE;
      busy_reg <= (state_next != iar_pkg::IAR_IDLE);
      done_reg <= exec_imm | exec_rot;
      mem_read_reg <= (state_next == iar_pkg::IAR_READ);
    end
  end

  // Accumulator and condition flags.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_reg <= `IAR_ACC_RST;
      carry_reg <= `IAR_FLAG_RST;
      zero_reg <= `IAR_FLAG_RST;
      sign_reg <= `IAR_FLAG_RST;
      parity_reg <= `IAR_FLAG_RST;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      sign_reg <= sign_next;
      parity_reg <= parity_next;
    end
  end

  // ==========================================================
  // Outputs
  assign ACC = acc_reg;
  assign CARRY = carry_reg;
  assign ZERO = zero_reg;
  assign SIGN = sign_reg;
  assign PARITY = parity_reg;
  assign BUSY = busy_reg;
  assign DONE = done_reg;
  assign MEM_READ = mem_read_reg;
  assign TSTATE = t_reg;

  // ==========================================================
  // Assertions
  property p_imm_len;
    @(posedge REF_CLK) disable iff (RST)
    (take && (OPCODE[7:6] == `IAR_IMM_HI) && (OPCODE[2:0] == `IAR_IMM_LO))
      |=> BUSY [*8] ##1 (!BUSY && DONE);
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate op not 8 states");
  property p_rot_len;
    @(posedge REF_CLK) disable iff (RST)
    (take && (OPCODE == `IAR_OP_ROTATE_LEFT_VIA_CARRY || OPCODE == `IAR_OP_ROTATE_RIGHT_CIRCULAR))
      |=> (BUSY && !MEM_READ) [*5] ##1 (!BUSY && DONE);
  endproperty
  a_rot_len: assert property (p_rot_len) else $error("rotate not 5 fetch states");
  property p_read_three;
    @(posedge REF_CLK) disable iff (RST)
    $rose(MEM_READ) |-> MEM_READ [*3] ##1 (!MEM_READ && DONE);
  endproperty
  a_read_three: assert property (p_read_three) else $error("read cycle length wrong");
  property p_sub_borrow;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && op_sbb)
      |=> ACC == 8'($past(acc_reg) - $past(DATA_IN) - {7'h00, $past(carry_reg)});
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");
  property p_chain;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && op_sui && (acc_reg < DATA_IN)) |=> CARRY;
  endproperty
  a_chain: assert property (p_chain) else $error("plain subtract lost borrow");
  property p_logic;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && is_logic) |=> (ACC == $past(logic_res)) && !CARRY
      && (ZERO == (ACC == 8'h00)) && (SIGN == ACC[7]);
  endproperty
  a_logic: assert property (p_logic) else $error("logic result wrong");
  property p_or_code;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && op_reg == 8'h34) |=> ACC == ($past(acc_reg) | $past(DATA_IN));
  endproperty
  a_or_code: assert property (p_or_code) else $error("or opcode wrong");

  property p_compare;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && op_cmp) |=> $stable(ACC) && (CARRY == ($past(DATA_IN) > ACC))
      && (ZERO == ($past(DATA_IN) == ACC));
  endproperty
  a_compare: assert property (p_compare) else $error("compare wrong");

  property p_compare_sp;
    @(posedge REF_CLK) disable iff (RST)
    (exec_imm && op_cmp) |=> (SIGN == $past(diff[7])) && (PARITY == ~(^$past(diff[7:0])));
  endproperty
  a_compare_sp: assert property (p_compare_sp) else $error("compare sign parity wrong");

  property p_rot_flags;
    @(posedge REF_CLK) disable iff (RST)
    exec_rot |=> $stable(ZERO) && $stable(SIGN) && $stable(PARITY);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate touched flags");

  property p_rot_left;
    @(posedge REF_CLK) disable iff (RST)
    (exec_rot && (op_rlc || op_ral)) |=> (ACC[7:1] == $past(acc_reg[6:0]))
      && (CARRY == $past(acc_reg[7]))
      && (ACC[0] == (op_rlc ? $past(acc_reg[7]) : $past(carry_reg)));
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("left rotate wrong");

  property p_rot_right;
    @(posedge REF_CLK) disable iff (RST)
    (exec_rot && (op_rrc || op_rar)) |=> (ACC[6:0] == $past(acc_reg[7:1]))
      && (CARRY == $past(acc_reg[0]))
      && (ACC[7] == (op_rrc ? $past(acc_reg[0]) : $past(carry_reg)));
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("right rotate wrong");
endmodule

// [dv/tb_immediate_alu_rotate.sv]
// Self-checking testbench of the immediate ALU and rotate datapath.
`timescale 1ns/100ps
`include "iar_cfg.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module tb_immediate_alu_rotate;
  // ==========================================================
  // Stimulus rows: load flag, opcode, accumulator, carry, byte two, then results.
  typedef struct packed {
    logic ld; logic [7:0] op; logic [7:0] a; logic c; logic [7:0] b;
    logic [7:0] ea; logic ec; logic ez; logic es; logic ep;
  } iar_row_t;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] data_in = 8'h00;
  logic load = 1'h0;
  logic [7:0] load_acc = 8'h00;
  logic load_carry = 1'h0;
  logic [7:0] acc;
  logic carry, zero, sign, parity, busy, done, mem_read;
  logic [2:0] tstate;
  int error_cnt = 0;
  int checked = 0;
  int n, nb, nm;
  iar_row_t rows [0:13] = '{
    '{1'h1, `IAR_OP_SUB_IMM_PLAIN, 8'h05, 1'h0, 8'h07, 8'hFE, 1'h1, 1'h0, 1'h1, 1'h0},
    '{1'h0, `IAR_OP_SUB_IMM_BORROW, 8'h00, 1'h0, 8'h00, 8'hFD, 1'h0, 1'h0, 1'h1, 1'h0},
    '{1'h1, `IAR_OP_SUB_IMM_BORROW, 8'h10, 1'h1, 8'h0F, 8'h00, 1'h0, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_AND_IMM, 8'hF0, 1'h1, 8'h3C, 8'h30, 1'h0, 1'h0, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_XOR_IMM, 8'hF0, 1'h1, 8'h3C, 8'hCC, 1'h0, 1'h0, 1'h1, 1'h1},
    '{1'h1, `IAR_OP_OR_IMM, 8'h81, 1'h1, 8'h02, 8'h83, 1'h0, 1'h0, 1'h1, 1'h0},
    '{1'h1, `IAR_OP_COMPARE_IMM, 8'h40, 1'h0, 8'h41, 8'h40, 1'h1, 1'h0, 1'h1, 1'h1},
    '{1'h1, `IAR_OP_COMPARE_IMM, 8'h41, 1'h1, 8'h41, 8'h41, 1'h0, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_ROTATE_LEFT_CIRCULAR, 8'h81, 1'h0, 8'h00, 8'h03, 1'h1, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_ROTATE_RIGHT_CIRCULAR, 8'h01, 1'h0, 8'h00, 8'h80, 1'h1, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_ROTATE_LEFT_VIA_CARRY, 8'h40, 1'h1, 8'h00, 8'h81, 1'h0, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_ROTATE_RIGHT_VIA_CARRY, 8'h02, 1'h1, 8'h00, 8'h81, 1'h0, 1'h1, 1'h0, 1'h1},
    '{1'h1, `IAR_OP_COMPARE_IMM, 8'h50, 1'h1, 8'h10, 8'h50, 1'h0, 1'h0, 1'h0, 1'h0},
    '{1'h1, `IAR_OP_ROTATE_RIGHT_VIA_CARRY, 8'h01, 1'h1, 8'h00, 8'h80, 1'h1, 1'h0, 1'h0, 1'h0}
  };

  iar_alu i_dut (
    .REF_CLK(ref_clk), .RST(rst), .START(start), .OPCODE(opcode), .DATA_IN(data_in),
    .LOAD(load), .LOAD_ACC(load_acc), .LOAD_CARRY(load_carry), .ACC(acc), .CARRY(carry),
    .ZERO(zero), .SIGN(sign), .PARITY(parity), .BUSY(busy), .DONE(done),
    .MEM_READ(mem_read), .TSTATE(tstate)
  );

  // ==========================================================
  // Clock, 100 ns period.
  always #50 ref_clk = ~ref_clk;

  // One idle cycle that optionally loads accumulator and carry.
  task automatic load_ab(input logic ld, input logic [7:0] a, input logic c);
    load = ld;
    load_acc = a;
    load_carry = c;
    @(negedge ref_clk);
    load = 1'h0;
  endtask

  // Byte two is only valid in the last read state, so an early or late sample shows up.
  task automatic wait_done(input logic [7:0] b, output int k, output int kb, output int km);
    k = 0;
    kb = 0;
    km = 0;
    data_in = ~b;
    while (k < 20 && done !== 1'h1) begin
      k++;
      kb += int'(busy);
      km += int'(mem_read);
      @(negedge ref_clk);
      data_in = (mem_read === 1'h1 && tstate === 3'h3) ? b : ~b;
    end
  endtask

  // Raises the request for one cycle and waits for the result cycle.
  task automatic go(input logic [7:0] op, input logic [7:0] b, output int k, output int kb,
                    output int km);
    start = 1'h1;
    opcode = op;
    @(negedge ref_clk);
    start = 1'h0;
    wait_done(b, k, kb, km);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the whole sequence needs about 190 cycles, so 3000 means a hang.
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'h0;
    foreach (rows[i]) begin
      load_ab(rows[i].ld, rows[i].a, rows[i].c);
      go(rows[i].op, rows[i].b, n, nb, nm);
      `CHK("acc", rows[i].ea, acc)
      `CHK("carry", rows[i].ec, carry)
      `CHK("zero", rows[i].ez, zero)
      `CHK("sign", rows[i].es, sign)
      `CHK("parity", rows[i].ep, parity)
      `CHK("states", (rows[i].op[2:0] == 3'h4) ? 8 : 5, n)
      `CHK("busy states", (rows[i].op[2:0] == 3'h4) ? 8 : 5, nb)
      `CHK("read states", (rows[i].op[2:0] == 3'h4) ? 3 : 0, nm)
    end
    $display("test table done");
    // A second request and a load in mid-operation must both be ignored.
    load_ab(1'h1, 8'h0F, 1'h0);
    start = 1'h1;
    opcode = `IAR_OP_AND_IMM;
    @(negedge ref_clk);
    opcode = `IAR_OP_ROTATE_LEFT_CIRCULAR;
    load = 1'h1;
    load_acc = 8'hFF;
    @(negedge ref_clk);
    start = 1'h0;
    load = 1'h0;
    wait_done(8'h3C, n, nb, nm);
    `CHK("busy and", 8'h0C, acc)
    `CHK("busy parity", 1'h1, parity)
    `CHK("busy states", 7, n)
    $display("test busy done");
    // Unknown opcodes keep everything but still take their time.
    go(8'h04, 8'h55, n, nb, nm);
    `CHK("unknown imm acc", 8'h0C, acc)
    `CHK("unknown imm states", 8, n)
    go(8'hFF, 8'h55, n, nb, nm);
    `CHK("unknown one acc", 8'h0C, acc)
    `CHK("unknown one states", 5, n)
    $display("test unknown done");
    // Back to back rotates, second request raised in the result cycle.
    go(`IAR_OP_ROTATE_LEFT_CIRCULAR, 8'h00, n, nb, nm);
    go(`IAR_OP_ROTATE_LEFT_VIA_CARRY, 8'h00, n, nb, nm);
    `CHK("b2b acc", 8'h30, acc)
    `CHK("b2b carry", 1'h0, carry)
    `CHK("b2b states", 5, n)
    $display("test back to back done");
    // Reset while idle, in the result cycle of the last rotate.
    rst = 1'h1;
    @(negedge ref_clk);
    `CHK("rst acc", 8'h00, acc)
    `CHK("rst flags", 4'h0, {carry, zero, sign, parity})
    `CHK("rst ctl", 6'h00, {busy, done, mem_read, tstate})
    rst = 1'h0;
    // A load and a rotate right after release show that the sequencer restarts cleanly.
    load_ab(1'h1, 8'h01, 1'h1);
    go(`IAR_OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, n, nb, nm);
    `CHK("post rst acc", 8'h80, acc)
    `CHK("post rst carry", 1'h1, carry)
    `CHK("post rst zero", 1'h0, zero)
    `CHK("post rst states", 5, n)
    $display("test reset done");
    end_sim();
  end
endmodule
